// ### ccs_regs.vh
// Constants of the card coupler serial control port.
// Assumes inclusion by the coupler core only; definitions, no logic.
`ifndef CCS_REGS_VH
`define CCS_REGS_VH

// =========================================
// Command byte fields
`define CCS_ADDR_MSB 7
`define CCS_ADDR_LSB 5
`define CCS_RST_BIT 4
`define CCS_IO_BIT 2
`define CCS_AUX_A_BIT 1
`define CCS_AUX_B_BIT 0
`define CCS_VCC_MSB 1
`define CCS_VCC_LSB 0
`define CCS_SPECIAL_PREFIX 3'h4
`define CCS_BYTE_BITS 4'h8

// =========================================
// Status byte fields
`define CCS_ST_PRESENT_BIT 4
`define CCS_ST_IO_BIT 3
`define CCS_ST_FAULT_BIT 2
`define CCS_ST_INT_BIT 1

// =========================================
// Reset values
`define CCS_CMD_RESET 8'h00
`define CCS_VCC_OFF 2'h0

`endif

// ### ccs_sync.v
// Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes the inputs come from pins or another clock domain.
`timescale 1ns/1ps

module ccs_sync #(
	parameter WIDTH = 1
) (
	clk,
	rst_n,
	din,
	dout
);
	input wire clk;
	input wire rst_n;
	input wire [WIDTH-1:0] din;
	output reg [WIDTH-1:0] dout;

	reg [WIDTH-1:0] stage;

	always @(posedge clk) begin
		if (!rst_n) begin
			stage <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end else begin
			stage <= din;
			dout <= stage;
		end
	end
endmodule // ccs_sync

// ### ccs_coupler.v
// Serial control port and card event interrupt of a smart card coupler.
// Assumes a host master drives sclk, cs_n and mosi; all pins asynchronous.
//
// Functional notes
// - Interrupt output idles high after power-on reset.
// - Insertion, extraction or supply fault pulls the interrupt low.
// - Interrupt set is not gated by chip select or address match.
// - Clear only with chip select low, addressed, bits 7..5 = 0xx or 101.
// - Insertion acknowledged by nonzero supply code; interrupt then released.
// - Extraction asserts interrupt, starts deactivation; zero code clears.
// - Supply overload forces supply code zero and asserts interrupt.
// - Reinsertion before acknowledge keeps interrupt low until acknowledged.
// - Chip select high deselects all; nothing takes effect.
// - Slave only; serial clock may idle low or high.
// - One write-only command register, one read-only status register.
// - Chip select high: serial activity ignored, miso not driven.
// - Chip select fall clears shift register and bit counter.
// - Mosi sampled on rising serial clock edge.
// - MSB first; first three bits compared with 0 and the two strapped aux contacts, or with 100 in special mode.
// - After eight bits, latch on chip select rise and update functions.
// - Several bytes per frame; each decoded, last addressed one applied on select rise.
// - Direction signal switches aux contacts between address and output.
// - Aux contacts sampled only as address strap while undriven, never card data.
// - Normal mode status bit 4 high when card present.
// - Card reset follows command bit 4 immediately during transfer.
`timescale 1ns/1ps
`include "ccs_regs.vh"

module ccs_coupler (
	clk,
	rst_n,
	sclk,
	cs_n,
	mosi,
	miso_o,
	miso_oe,
	int_n_o,
	int_n_oe,
	aux_contact_a_i,
	aux_contact_a_o,
	aux_contact_a_oe,
	aux_contact_b_i,
	aux_contact_b_o,
	aux_contact_b_oe,
	card_presence_switch,
	detect_polarity,
	special_mode,
	supply_overload,
	card_io_line,
	card_supply_out,
	card_reset_out,
	card_deactivation_seq,
	command_latch
);
	input wire clk;
	input wire rst_n;
	input wire sclk;
	input wire cs_n;
	input wire mosi;
	output wire miso_o;
	output wire miso_oe;
	output wire int_n_o;
	output wire int_n_oe;
	input wire aux_contact_a_i;
	output reg aux_contact_a_o;
	output wire aux_contact_a_oe;
	input wire aux_contact_b_i;
	output reg aux_contact_b_o;
	output wire aux_contact_b_oe;
	input wire card_presence_switch;
	input wire detect_polarity;
	input wire special_mode;
	input wire supply_overload;
	input wire card_io_line;
	output reg [1:0] card_supply_out;
	output reg card_reset_out;
	output reg card_deactivation_seq;
	output reg [7:0] command_latch;

	// =========================================
	// Input synchronisers
	wire [8:0] raw_in;
	wire [8:0] syn;
	// Select enters inverted: the synchroniser clears to zero, and that
	// zero must read as deselected, or reset fakes a frame start.
	assign raw_in = {sclk, ~cs_n, mosi, aux_contact_a_i, aux_contact_b_i,
		card_presence_switch, detect_polarity, supply_overload,
		card_io_line};

	ccs_sync #(
		.WIDTH(9)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(raw_in),
		.dout(syn)
	);

	wire s_sclk = syn[8];
	wire s_cs_n = ~syn[7];
	wire s_mosi = syn[6];
	wire s_aux_a = syn[5];
	wire s_aux_b = syn[4];
	wire s_switch = syn[3];
	wire s_pol = syn[2];
	wire s_ovl = syn[1];
	wire s_io = syn[0];

	// Address match: 2-bit strap against the low two address bits,
	// top address bit distinguishes the special prefix.
	function addr_match;
		input [2:0] addr;
		input [1:0] strap;
		input special;
		begin
			if (special)
				addr_match = (addr == `CCS_SPECIAL_PREFIX);
			else
				addr_match = (addr[1:0] == strap) &&
					(addr[2] == 1'b0);
		end
	endfunction

	// Clear-capable command codes: 0xx or 101
	function clear_code;
		input [2:0] addr;
		begin
			clear_code = (addr[2] == 1'b0) || (addr == 3'h5);
		end
	endfunction

	// =========================================
	// Edge detection
	reg sclk_d;
	reg cs_n_d;
	reg present_d;
	wire sclk_rise = s_sclk & ~sclk_d;
	wire sclk_fall = ~s_sclk & sclk_d;
	wire cs_fall = ~s_cs_n & cs_n_d;
	wire cs_rise = s_cs_n & ~cs_n_d;
	// Presence after programmable switch polarity
	wire present = s_switch ^ s_pol;
	wire insert_ev = present & ~present_d;
	wire extract_ev = ~present & present_d;

	// =========================================
	// Serial shifter
	reg [7:0] shift;
	reg [3:0] bit_cnt;
	reg selected;
	reg [7:0] pending;
	reg pending_valid;
	reg [7:0] status_shift;
	reg miso_bit;
	reg [1:0] strap;
	reg int_flag;
	reg fault_flag;
	wire [7:0] next_shift = {shift[6:0], s_mosi};
	wire [7:0] status_byte;

	// Presence bit, polarity-independent in normal mode
	assign status_byte = {3'h0,
		special_mode ? s_switch : present,
		s_io, fault_flag, int_flag, 1'b0};

	always @(posedge clk) begin
		if (!rst_n) begin
			sclk_d <= 1'b0;
			cs_n_d <= 1'b1;
			present_d <= 1'b0;
			shift <= `CCS_CMD_RESET;
			bit_cnt <= 4'h0;
			selected <= 1'b0;
			pending <= `CCS_CMD_RESET;
			pending_valid <= 1'b0;
			status_shift <= 8'h00;
			miso_bit <= 1'b0;
			strap <= 2'h3;
		end else begin
			sclk_d <= s_sclk;
			cs_n_d <= s_cs_n;
			present_d <= present;
			// Strap sampled while contacts are inputs
			// A released contact settles two clocks later, before a frame
			if (s_cs_n && !aux_contact_a_oe)
				strap <= {s_aux_a, s_aux_b};
			if (cs_fall) begin
				shift <= 8'h00;
				bit_cnt <= 4'h0;
				selected <= 1'b0;
				status_shift <= status_byte;
				miso_bit <= status_byte[7];
			// Serial activity ignored with select high
			end else if (!s_cs_n) begin
				// Edge-based, so either clock idle level works
				// Sample data on rising serial clock
				if (sclk_rise) begin
					shift <= next_shift;
					if (bit_cnt == `CCS_BYTE_BITS - 4'h1)
						bit_cnt <= 4'h0;
					else
						bit_cnt <= bit_cnt + 4'h1;
					if (bit_cnt == 4'h2)
						selected <= addr_match(next_shift[2:0],
							strap, special_mode);
					// Each addressed byte kept for latch
					if (bit_cnt == `CCS_BYTE_BITS - 4'h1 &&
						selected) begin
						pending <= next_shift;
						pending_valid <= 1'b1;
					end
				end
				if (sclk_fall) begin
					status_shift <= {status_shift[6:0], 1'b0};
					miso_bit <= status_shift[6];
				end
			end
			// A cut byte never sets pending_valid, so only whole bytes apply
			if (cs_rise)
				pending_valid <= 1'b0;
		end
	end

	// Only the matched chip drives miso
	// Miso is the only serial port line driven
	// Not in a frame's first cycle: selected still holds the last frame
	assign miso_oe = ~s_cs_n & ~cs_n_d & selected;
	assign miso_o = miso_bit;

	// =========================================
	// Command latch and controlled functions
	// Latch on chip select rise after eight bits
	// Nothing applied while select stays high
	wire apply = cs_rise & pending_valid;
	wire [2:0] p_addr = pending[`CCS_ADDR_MSB:`CCS_ADDR_LSB];
	wire [1:0] p_vcc = pending[`CCS_VCC_MSB:`CCS_VCC_LSB];

	always @(posedge clk) begin
		if (!rst_n) begin
			command_latch <= `CCS_CMD_RESET;
			card_supply_out <= `CCS_VCC_OFF;
			card_reset_out <= 1'b0;
			card_deactivation_seq <= 1'b0;
			aux_contact_a_o <= 1'b0;
			aux_contact_b_o <= 1'b0;
			fault_flag <= 1'b0;
			int_flag <= 1'b0;
		end else begin
			// Reset pin follows bit 4 while shifting
			if (!s_cs_n && selected && sclk_rise &&
				bit_cnt == 4'h3)
				card_reset_out <= s_mosi;
			if (apply) begin
				command_latch <= pending;
				card_reset_out <= pending[`CCS_RST_BIT];
				if (p_addr[2] == 1'b0)
					card_supply_out <= p_vcc;
				// Aux outputs carry host data only
				aux_contact_a_o <= pending[`CCS_AUX_A_BIT];
				aux_contact_b_o <= pending[`CCS_AUX_B_BIT];
				if (p_addr[2] == 1'b0 && p_vcc != `CCS_VCC_OFF)
					card_deactivation_seq <= 1'b0;
			end
			if (extract_ev || s_ovl) begin
				card_deactivation_seq <= 1'b1;
				card_supply_out <= `CCS_VCC_OFF;
				card_reset_out <= 1'b0;
			end
			// Fault stays until a live supply code is applied again
			if (s_ovl)
				fault_flag <= 1'b1;
			else if (apply && p_vcc != `CCS_VCC_OFF)
				fault_flag <= 1'b0;
			// No select or address gating on set
			// Set wins, so reinsertion keeps it low
			// Clear only on addressed clear code
			if (insert_ev || extract_ev || (s_ovl && !fault_flag))
				int_flag <= 1'b1;
			else if (apply && clear_code(p_addr))
				int_flag <= 1'b0;
		end
	end

	assign int_n_o = 1'b0;
	assign int_n_oe = int_flag;

	// Contacts drive only with card supply on
	assign aux_contact_a_oe = (card_supply_out != `CCS_VCC_OFF);
	assign aux_contact_b_oe = (card_supply_out != `CCS_VCC_OFF);
endmodule // ccs_coupler

// ### ccs_checker.sv
// Port checker of the coupler: interrupt, supply and latch timing.
// Assumes a bind onto ccs_coupler; pins are synchronised inside.
`timescale 1ns/1ps

module ccs_checker (
	input logic clk,
	input logic rst_n,
	input logic cs_n,
	input logic miso_oe,
	input logic int_n_oe,
	input logic aux_contact_a_oe,
	input logic supply_overload,
	input logic card_presence_switch,
	input logic detect_polarity,
	input logic [1:0] card_supply_out,
	input logic card_deactivation_seq,
	input logic [7:0] command_latch
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// Interrupt
	int_idle_a: assert property ($rose(rst_n) |-> !int_n_oe)
		else $error("interrupt low at reset release");
	int_insert_a: assert property (!detect_polarity &&
		$rose(card_presence_switch) |-> ##[1:8] int_n_oe)
		else $error("insertion raised no interrupt");
	int_extract_a: assert property (!detect_polarity &&
		$fell(card_presence_switch) |-> ##[1:8]
		(int_n_oe && card_deactivation_seq))
		else $error("extraction not handled");
	int_overload_a: assert property ($rose(supply_overload)
		|-> ##[1:8] (int_n_oe && card_supply_out == 2'h0))
		else $error("overload not handled");
	int_hold_a: assert property ((int_n_oe && cs_n) [*8]
		|=> int_n_oe)
		else $error("interrupt cleared without a frame");
	// ==========
	// Serial port
	latch_quiet_a: assert property (cs_n [*8]
		|=> $stable(command_latch))
		else $error("command changed outside a frame");
	supply_src_a: assert property ($changed(card_supply_out) &&
		card_supply_out != 2'h0 |-> card_supply_out == command_latch[1:0])
		else $error("supply code not from command");
	miso_idle_a: assert property (cs_n [*4] |-> !miso_oe)
		else $error("miso driven while deselected");
	aux_dir_a: assert property ((card_supply_out != 2'h0) [*2]
		|-> aux_contact_a_oe)
		else $error("aux contact not driven with supply on");
endmodule // ccs_checker

// ### ccs_host.sv
// Host master model: one command byte per chip select frame.
// Assumes a 64 ns serial clock idling low.
`timescale 1ns/1ps

module ccs_host (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input logic miso,
	output logic [7:0] rx
);
	initial begin
		rx = 8'h00;
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end
	// host drives all, msb first, data set on low
	task automatic xfer(input logic [7:0] b);
		cs_n = 1'b0;
		#200;
		for (int i = 7; i >= 0; i--) begin
			mosi = b[i];
			// status bit taken as the clock rises
			#32 rx[i] = miso;
			sclk = 1'b1;
			#32 sclk = 1'b0;
		end
		// Delays keep every change on a falling system clock edge
		#96 cs_n = 1'b1;
		// Released line must not keep the last bit
		mosi = ~b[0];
		#304;
	endtask
endmodule // ccs_host

// ### testbench.sv
// Self-checking bench of the coupler with a host model.
// Assumes strap pins pulled high, so this chip answers to 011 in normal mode.
`timescale 1ns/1ps

module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sw = 1'b0;
	logic ovl = 1'b0;
	logic sclk, cs_n, mosi, miso_o, miso_oe, int_n_o, int_n_oe;
	logic a_o, a_oe, b_o, b_oe, rst_o, deact;
	logic [1:0] vcc;
	logic [7:0] cmd, rx;
	logic pol = 1'b0;
	logic spec = 1'b0;
	logic cio = 1'b0;
	int miscompares = 0;
	int check_count = 0;
	// Open contacts read high through the bias
	wire a_pin = a_oe ? a_o : 1'b1;
	wire b_pin = b_oe ? b_o : 1'b1;
	wire int_line = int_n_oe ? int_n_o : 1'b1;
	// Undriven miso floats high through the host pull-up
	wire miso_line = miso_oe ? miso_o : 1'b1;

	always #4 clk = ~clk;

	ccs_host i_ccs_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso_line), .rx(rx));
	ccs_coupler i_ccs_coupler (.clk(clk), .rst_n(rst_n), .sclk(sclk),
		.cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
		.int_n_o(int_n_o), .int_n_oe(int_n_oe), .aux_contact_a_i(a_pin),
		.aux_contact_a_o(a_o), .aux_contact_a_oe(a_oe),
		.aux_contact_b_i(b_pin), .aux_contact_b_o(b_o),
		.aux_contact_b_oe(b_oe), .card_presence_switch(sw),
		.detect_polarity(pol), .special_mode(spec),
		.supply_overload(ovl), .card_io_line(cio),
		.card_supply_out(vcc), .card_reset_out(rst_o),
		.card_deactivation_seq(deact), .command_latch(cmd));

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	task wt(input int n);
		repeat (n) @(negedge clk);
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task t_insert;
		@(negedge clk) sw = 1'b1;
		wt(8);
		chk("int", 0, int_line);
		i_ccs_host.xfer(8'h41);
		chk("status", 8'hff, rx);
		wt(8);
		chk("int", 0, int_line);
		chk("supply", 0, vcc);
		i_ccs_host.xfer(8'h61);
		chk("status", 8'hf2, rx);
		wt(8);
		chk("int", 1, int_line);
		chk("latch", 8'h61, cmd);
		chk("aux a", 0, a_pin);
		chk("aux b", 1, b_pin);
	endtask

	task t_extract;
		@(negedge clk) sw = 1'b0;
		wt(8);
		chk("int", 0, int_line);
		chk("deact", 1, deact);
		i_ccs_host.xfer(8'h60);
		chk("status", 8'he2, rx);
		wt(8);
		chk("int", 1, int_line);
		chk("supply", 0, vcc);
	endtask

	task t_overload;
		@(negedge clk) cio = 1'b1;
		wt(4);
		i_ccs_host.xfer(8'h72);
		chk("status", 8'he8, rx);
		wt(8);
		chk("supply", 2, vcc);
		chk("card reset", 1, rst_o);
		@(negedge clk) ovl = 1'b1;
		wt(8);
		chk("supply", 0, vcc);
		chk("int", 0, int_line);
		@(negedge clk) ovl = 1'b0;
		i_ccs_host.xfer(8'h60);
		chk("status", 8'hee, rx);
		wt(8);
		chk("int", 1, int_line);
	endtask

	task t_reinsert;
		@(negedge clk) sw = 1'b1;
		wt(8);
		@(negedge clk) sw = 1'b0;
		wt(8);
		@(negedge clk) sw = 1'b1;
		wt(8);
		chk("int", 0, int_line);
		i_ccs_host.xfer(8'h61);
		chk("status", 8'hfe, rx);
		wt(8);
		chk("int", 1, int_line);
	endtask

	task t_special;
		@(negedge clk) begin
			spec = 1'b1;
			pol = 1'b1;
		end
		wt(8);
		chk("int", 0, int_line);
		chk("supply", 0, vcc);
		i_ccs_host.xfer(8'h95);
		chk("status", 8'hfa, rx);
		wt(8);
		chk("latch", 8'h95, cmd);
		chk("card reset", 1, rst_o);
		chk("int", 0, int_line);
	endtask

	initial begin
		wt(3);
		rst_n = 1'b1;
		wt(6);
		chk("int", 1, int_line);
		chk("supply", 0, vcc);
		t_insert;
		t_extract;
		t_overload;
		t_reinsert;
		t_special;
		give_verdict;
	end

	// Whole run is near 9 us; over six times that means a hang
	initial begin
		#60000;
		miscompares++;
		give_verdict;
	end
endmodule // testbench

bind ccs_coupler ccs_checker i_ccs_checker (.clk(clk), .rst_n(rst_n),
	.cs_n(cs_n), .miso_oe(miso_oe), .int_n_oe(int_n_oe),
	.aux_contact_a_oe(aux_contact_a_oe), .supply_overload(supply_overload),
	.card_presence_switch(card_presence_switch),
	.detect_polarity(detect_polarity), .card_supply_out(card_supply_out),
	.card_deactivation_seq(card_deactivation_seq),
	.command_latch(command_latch));
